//--- hdl/cfg_stream_map.svh
`ifndef CFG_STREAM_MAP_SVH
`define CFG_STREAM_MAP_SVH
// ----------------------------------------
// register addresses
// ----------------------------------------
`define ADDR_RECEIVER_IF_CONFIG 4'h0
`define ADDR_GAIN_OUTPUT_CONFIG 4'h1
`define ADDR_SUPPORT_STREAM_CONFIG 4'h2
`define ADDR_SYNTH_CLOCK_CONFIG 4'h3
`define ADDR_SYNTH_INT_REF_RATIO 4'h4
`define ADDR_SYNTH_FRACTION_RATIO 4'h5
`define ADDR_STREAM_FRAME_COUNT 4'h6
`define ADDR_SAMPLE_CLOCK_FRACTION 4'h7
`define ADDR_TEST_MODE_FIRST 4'h8
`define ADDR_TEST_MODE_SECOND 4'h9
`define ADDR_LAST 4'h9
// ----------------------------------------
// power-on values
// ----------------------------------------
`define RST_RECEIVER_IF_CONFIG 28'ha2919a3
`define RST_GAIN_OUTPUT_CONFIG 28'h055028c
`define RST_SUPPORT_STREAM_CONFIG 28'heafe1dc
`define RST_SYNTH_CLOCK_CONFIG 28'h9ec0008
`define RST_SYNTH_INT_REF_RATIO 28'h0c00080
`define RST_SYNTH_FRACTION_RATIO 28'h8000070
`define RST_STREAM_FRAME_COUNT 28'h8000000
`define RST_SAMPLE_CLOCK_FRACTION 28'h10061b2
`define RST_TEST_MODE_FIRST 28'h1e0f401
`define RST_TEST_MODE_SECOND 28'h28c0402
// ----------------------------------------
// strap state values that differ from power-on
// ----------------------------------------
`define ST2_RECEIVER_IF_CONFIG 28'ha2919a7
`define ST56_RECEIVER_IF_CONFIG 28'ha293573
`define ST7_RECEIVER_IF_CONFIG 28'ha29b26b
`define ST02_GAIN_OUTPUT_CONFIG 28'h055121c
`define ST567_GAIN_OUTPUT_CONFIG 28'h855030c
`define ST3_SYNTH_INT_REF_RATIO 28'h0c00100
`define ST4_SYNTH_INT_REF_RATIO 28'h3d62300
`define ST5_SYNTH_INT_REF_RATIO 28'h0ba00d0
`define ST7_SYNTH_INT_REF_RATIO 28'h0bc80d0
`define ST7_TEST_MODE_SECOND 28'h7cc0403
// ----------------------------------------
// field positions
// ----------------------------------------
`define BIT_STREAM_PATH_ENABLE 11
`define BIT_STREAM_BEGIN_CMD 10
`define BIT_STREAM_END_CMD 9
`define MSB_STREAM_LANE_SELECT 5
`define LSB_STREAM_LANE_SELECT 4
`define BIT_FRAME_NUMBER_INSERT_EN 3
`define BIT_TIME_SYNC_ALWAYS 2
`define BIT_WORD_SYNC_EN 1
`define BIT_STREAM_COUNTER_RST 0
`define BIT_FRAC_DIVIDER_BYPASS 27
`define BIT_SAMPLE_CLOCK_SOURCE 26
// ----------------------------------------
// stream timing
// ----------------------------------------
`define SLICE_BITS 16
`define CFG_DATA_BITS 28
`define CFG_WORD_BITS 32
`define TSYNC_PERIOD_MIN 128
`define TSYNC_PERIOD_MAX 16384
`endif

//--- hdl/cfg_stream_pkg.sv
package cfg_stream_pkg;
  typedef logic [27:0] cfg_word_t;
  typedef enum logic [1:0] {
    lanes_zero = 2'h0,
    lanes_zero_one = 2'h1,
    lanes_zero_two = 2'h2,
    lanes_all = 2'h3
  } lane_set_e;
  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_stamp = 3'b010,
    st_data = 3'b100
  } stream_frame_count_state_e;
endpackage : cfg_stream_pkg

//--- hdl/sample_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sample_bus_if;
  logic [3:0] lane_bits;
  logic sample_tick;
  logic block_done;
  logic [15:0] hold [4];
  modport capture (input lane_bits, input sample_tick, output block_done, output hold);
  modport user (output lane_bits, output sample_tick, input block_done, input hold);
endinterface : sample_bus_if
`default_nettype wire

//--- hdl/sample_capture.sv
`timescale 1ns/1ps
`default_nettype none
`include "cfg_stream_map.svh"
module sample_capture (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // sample side
  sample_bus_if.capture bus
);
  logic [15:0] acc_r [4];
  logic [15:0] acc_nxt [4];
  logic [15:0] hold_r [4];
  logic [15:0] hold_nxt [4];
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic done_nxt;
  logic done_r;

  always_comb begin
    acc_nxt = acc_r;
    hold_nxt = hold_r;
    cnt_nxt = cnt_r;
    done_nxt = 1'b0;
    if (bus.sample_tick) begin
      for (int k = 0; k < 4; k++) begin
        acc_nxt[k] = {acc_r[k][14:0], bus.lane_bits[k]}; // [RQ5] [RQ20]
      end
      cnt_nxt = cnt_r + 4'h1;
      if (cnt_r == 4'hf) begin
        for (int k = 0; k < 4; k++) begin
          hold_nxt[k] = {acc_r[k][14:0], bus.lane_bits[k]}; // [RQ6]
        end
        done_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      for (int k = 0; k < 4; k++) begin
        acc_r[k] <= 16'h0000;
        hold_r[k] <= 16'h0000;
      end
      cnt_r <= 4'h0;
      done_r <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      hold_r <= hold_nxt;
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  assign bus.hold = hold_r;
  assign bus.block_done = done_r;
endmodule : sample_capture
`default_nettype wire

//--- hdl/cfg_stream_top.sv
// Contract
// RQ1 - slices of 16 bits, lane order 0..3
// RQ2 - lane select picks one of four sets
// RQ3 - two lanes alternate, one lane only zero
// RQ4 - stream clock fast enough for lanes
// RQ5 - samples gathered into four holding registers
// RQ6 - holding moves to shifters each 16 samples
// RQ7 - zeros after valid bits until next set
// RQ8 - word sync marks each slice start
// RQ9 - time sync every 128..16384 sample clocks
// RQ10 - bypass bit chooses divided or direct clock
// RQ11 - source bit picks multiplier or raw reference
// RQ12 - strap high: pins pick preset state
// RQ13 - each preset state loads its values
// RQ14 - strap low: power-on loads defaults
// RQ15 - power-up reset loads register settings
// RQ16 - 32-bit words msb first while select low
// RQ17 - 4-bit address, ten registers
// RQ18 - frame count and clock fraction registers
// RQ19 - 28 data then 4 address, write on rise
// RQ20 - lanes: I sign, I mag, Q sign, Q mag
// RQ21 - begin/end command edges start and stop
// RQ22 - frame number inserted when enabled
`timescale 1ns/1ps
`default_nettype none
`include "cfg_stream_map.svh"
module cfg_stream_top
  import cfg_stream_pkg::*;
#(
  parameter int TSYNC_PERIOD = 16384
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // configuration port
  input wire logic strap_mode_pin_i,
  input wire logic cfg_sclk_i,
  input wire logic cfg_serial_in_i,
  input wire logic cfg_sel_n_i,
  // sample input
  input wire logic [3:0] adc_bits_i,
  input wire logic adc_tick_i,
  input wire logic stream_tick_i,
  // stream output
  output logic stream_data_o,
  output logic stream_clk_en_o,
  output logic word_sync_out_o,
  output logic time_sync_o,
  // clock steering
  output logic frac_divider_bypass_o,
  output logic sample_clock_source_o,
  // register view
  output var cfg_word_t cfg_regs_o [10]
);
  // ----------------------------------------
  // register bank
  // ----------------------------------------
  cfg_word_t regs_r [10];
  cfg_word_t regs_nxt [10];
  logic [31:0] shift_r;
  logic [31:0] shift_nxt;
  logic sclk_d_r;
  logic sel_d_r;
  logic [5:0] nbits_r;
  logic [5:0] nbits_nxt;
  logic boot_r;

  function automatic cfg_word_t preset(input logic [3:0] a, input logic [2:0] s);
    cfg_word_t v;
    v = 28'h0;
    case (a)
      4'h0: v = (s == 3'h2) ? `ST2_RECEIVER_IF_CONFIG :
                (s == 3'h5 || s == 3'h6) ? `ST56_RECEIVER_IF_CONFIG :
                (s == 3'h7) ? `ST7_RECEIVER_IF_CONFIG : `RST_RECEIVER_IF_CONFIG;
      4'h1: v = (s == 3'h0 || s == 3'h2) ? `ST02_GAIN_OUTPUT_CONFIG :
                (s >= 3'h5) ? `ST567_GAIN_OUTPUT_CONFIG : `RST_GAIN_OUTPUT_CONFIG;
      4'h2: v = `RST_SUPPORT_STREAM_CONFIG;
      4'h3: v = `RST_SYNTH_CLOCK_CONFIG;
      4'h4: v = (s == 3'h3) ? `ST3_SYNTH_INT_REF_RATIO :
                (s == 3'h4) ? `ST4_SYNTH_INT_REF_RATIO :
                (s == 3'h5) ? `ST5_SYNTH_INT_REF_RATIO :
                (s == 3'h7) ? `ST7_SYNTH_INT_REF_RATIO : `RST_SYNTH_INT_REF_RATIO;
      4'h5: v = `RST_SYNTH_FRACTION_RATIO;
      4'h6: v = `RST_STREAM_FRAME_COUNT;
      4'h7: v = `RST_SAMPLE_CLOCK_FRACTION;
      4'h8: v = `RST_TEST_MODE_FIRST;
      4'h9: v = (s == 3'h7) ? `ST7_TEST_MODE_SECOND : `RST_TEST_MODE_SECOND;
      default: v = 28'h0;
    endcase
    return v;
  endfunction : preset

  always_comb begin
    regs_nxt = regs_r;
    shift_nxt = shift_r;
    nbits_nxt = nbits_r;
    if (boot_r) begin
      // strap levels caught one cycle after reset release
      // preset state 1 matches every power-on value
      for (int k = 0; k < 10; k++) begin
        regs_nxt[k] = strap_mode_pin_i ?
          preset(4'(k), {cfg_sclk_i, cfg_serial_in_i, cfg_sel_n_i}) : // [RQ12] [RQ13]
          preset(4'(k), 3'h1); // [RQ14] [RQ15]
      end
    end else if (strap_mode_pin_i) begin
      nbits_nxt = 6'h0; // [RQ12]
    end else begin
      if (!cfg_sel_n_i && cfg_sclk_i && !sclk_d_r) begin
        shift_nxt = {shift_r[30:0], cfg_serial_in_i}; // [RQ16]
        if (nbits_r != 6'h3f) nbits_nxt = nbits_r + 6'h1;
      end
      if (cfg_sel_n_i && !sel_d_r) begin
        if (nbits_r == 6'(`CFG_WORD_BITS) && shift_r[3:0] <= `ADDR_LAST) // [RQ17]
          regs_nxt[shift_r[3:0]] = shift_r[31:4]; // [RQ19] [RQ18]
        nbits_nxt = 6'h0;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      for (int k = 0; k < 10; k++) regs_r[k] <= 28'h0;
      shift_r <= 32'h0;
      nbits_r <= 6'h0;
      sclk_d_r <= 1'b0;
      sel_d_r <= 1'b1;
      boot_r <= 1'b1;
    end else begin
      regs_r <= regs_nxt;
      shift_r <= shift_nxt;
      nbits_r <= nbits_nxt;
      sclk_d_r <= cfg_sclk_i;
      sel_d_r <= cfg_sel_n_i;
      boot_r <= 1'b0;
    end
  end

  assign cfg_regs_o = regs_r;
  cfg_word_t stream_frame_count_cfg;
  assign stream_frame_count_cfg = regs_r[2];
  assign frac_divider_bypass_o = regs_r[7][`BIT_FRAC_DIVIDER_BYPASS]; // [RQ10]
  assign sample_clock_source_o = regs_r[7][`BIT_SAMPLE_CLOCK_SOURCE]; // [RQ11]

  // ----------------------------------------
  // capture and serializer
  // ----------------------------------------
  sample_bus_if sbus ();
  assign sbus.lane_bits = adc_bits_i;
  assign sbus.sample_tick = adc_tick_i;
  sample_capture u_cap (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .bus(sbus.capture)
  );

  stream_frame_count_state_e st_r, st_nxt;
  logic [15:0] shr_r [4];
  logic [15:0] shr_nxt [4];
  logic [1:0] lane_r, lane_nxt;
  logic [4:0] bit_r, bit_nxt;
  logic [27:0] frame_r, frame_nxt;
  logic active_r, active_nxt;
  logic pend_r, pend_nxt;
  logic begin_d_r, end_d_r;
  logic out_r, out_nxt;
  logic wsync_r, wsync_nxt;
  logic [14:0] tcnt_r, tcnt_nxt;
  logic tsync_r, tsync_nxt;
  lane_set_e lsel;
  assign lsel = lane_set_e'(stream_frame_count_cfg[`MSB_STREAM_LANE_SELECT:`LSB_STREAM_LANE_SELECT]); // [RQ2]

  function automatic logic [1:0] next_lane(input lane_set_e s, input logic [1:0] l);
    logic [1:0] n;
    n = 2'h0;
    case (s)
      lanes_zero: n = 2'h0;
      lanes_zero_one: n = (l == 2'h0) ? 2'h1 : 2'h0;
      lanes_zero_two: n = (l == 2'h0) ? 2'h2 : 2'h0;
      default: n = l + 2'h1;
    endcase
    return n;
  endfunction : next_lane

  function automatic logic last_lane(input lane_set_e s, input logic [1:0] l);
    logic r;
    r = 1'b0;
    case (s)
      lanes_zero: r = 1'b1;
      lanes_zero_one: r = (l == 2'h1);
      lanes_zero_two: r = (l == 2'h2);
      default: r = (l == 2'h3);
    endcase
    return r;
  endfunction : last_lane

  logic enab;
  assign enab = stream_frame_count_cfg[`BIT_STREAM_PATH_ENABLE];

  always_comb begin
    st_nxt = st_r;
    shr_nxt = shr_r;
    lane_nxt = lane_r;
    bit_nxt = bit_r;
    frame_nxt = frame_r;
    active_nxt = active_r;
    pend_nxt = pend_r;
    out_nxt = out_r;
    wsync_nxt = 1'b0;
    tcnt_nxt = tcnt_r;
    tsync_nxt = 1'b0;
    if (stream_frame_count_cfg[`BIT_STREAM_BEGIN_CMD] && !begin_d_r) active_nxt = 1'b1; // [RQ21]
    if (stream_frame_count_cfg[`BIT_STREAM_END_CMD] && !end_d_r) active_nxt = 1'b0; // [RQ21]
    if (sbus.block_done) begin
      shr_nxt = sbus.hold; // [RQ6]
      pend_nxt = 1'b1;
    end
    if (adc_tick_i) begin
      if (tcnt_r >= 15'(TSYNC_PERIOD - 1)) begin
        tcnt_nxt = 15'h0;
        tsync_nxt = stream_frame_count_cfg[`BIT_TIME_SYNC_ALWAYS] ? enab : active_r; // [RQ9]
      end else begin
        tcnt_nxt = tcnt_r + 15'h1;
      end
    end
    if (stream_tick_i) begin
      case (st_r)
        st_idle: begin
          out_nxt = 1'b0; // [RQ7]
          if (pend_r && active_r && enab) begin
            pend_nxt = sbus.block_done;
            lane_nxt = 2'h0;
            bit_nxt = 5'h0;
            wsync_nxt = stream_frame_count_cfg[`BIT_WORD_SYNC_EN]; // [RQ8]
            if (stream_frame_count_cfg[`BIT_FRAME_NUMBER_INSERT_EN]) begin
              st_nxt = st_stamp; // [RQ22]
              out_nxt = frame_r[27];
            end else begin
              st_nxt = st_data;
              out_nxt = shr_r[0][15]; // [RQ1]
            end
          end
        end
        st_stamp: begin
          bit_nxt = bit_r + 5'h1;
          if (bit_r == 5'(`CFG_DATA_BITS - 1)) begin
            st_nxt = st_data;
            bit_nxt = 5'h0;
            wsync_nxt = stream_frame_count_cfg[`BIT_WORD_SYNC_EN];
            out_nxt = shr_r[0][15];
            frame_nxt = frame_r + 28'h1;
          end else begin
            out_nxt = frame_r[5'(26) - bit_r];
          end
        end
        st_data: begin
          bit_nxt = bit_r + 5'h1;
          if (bit_r == 5'(`SLICE_BITS - 1)) begin
            bit_nxt = 5'h0;
            if (last_lane(lsel, lane_r)) begin // [RQ3]
              st_nxt = st_idle;
              lane_nxt = 2'h0;
              out_nxt = 1'b0; // [RQ7]
              if (!stream_frame_count_cfg[`BIT_FRAME_NUMBER_INSERT_EN]) frame_nxt = frame_r + 28'h1;
            end else begin
              lane_nxt = next_lane(lsel, lane_r); // [RQ1] [RQ3]
              wsync_nxt = stream_frame_count_cfg[`BIT_WORD_SYNC_EN]; // [RQ8]
              out_nxt = shr_r[next_lane(lsel, lane_r)][15];
            end
          end else begin
            out_nxt = shr_r[lane_r][4'(14) - bit_r[3:0]];
          end
        end
        default: st_nxt = st_idle;
      endcase
    end
    if (stream_frame_count_cfg[`BIT_STREAM_COUNTER_RST] || !active_nxt) begin
      st_nxt = st_idle;
      bit_nxt = 5'h0;
      lane_nxt = 2'h0;
      // no sync pulse for a slice that is cut before it starts
      wsync_nxt = 1'b0;
      out_nxt = 1'b0;
      if (stream_frame_count_cfg[`BIT_STREAM_COUNTER_RST]) frame_nxt = 28'h0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      st_r <= st_idle;
      for (int k = 0; k < 4; k++) shr_r[k] <= 16'h0;
      lane_r <= 2'h0;
      bit_r <= 5'h0;
      frame_r <= 28'h0;
      active_r <= 1'b0;
      pend_r <= 1'b0;
      begin_d_r <= 1'b0;
      end_d_r <= 1'b0;
      out_r <= 1'b0;
      wsync_r <= 1'b0;
      tcnt_r <= 15'h0;
      tsync_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      shr_r <= shr_nxt;
      lane_r <= lane_nxt;
      bit_r <= bit_nxt;
      frame_r <= frame_nxt;
      active_r <= active_nxt;
      pend_r <= pend_nxt;
      begin_d_r <= stream_frame_count_cfg[`BIT_STREAM_BEGIN_CMD];
      end_d_r <= stream_frame_count_cfg[`BIT_STREAM_END_CMD];
      out_r <= out_nxt;
      wsync_r <= wsync_nxt;
      tcnt_r <= tcnt_nxt;
      tsync_r <= tsync_nxt;
    end
  end

  assign stream_data_o = out_r;
  assign stream_clk_en_o = active_r & enab; // [RQ21]
  assign word_sync_out_o = wsync_r;
  assign time_sync_o = tsync_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_idle_zero;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      (st_r == st_idle) |-> !stream_data_o;
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("data not zero in gap"); // [RQ7]
  property p_wsync_start;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      word_sync_out_o |-> (st_r != st_idle) && bit_r == 5'h0;
  endproperty
  a_wsync_start: assert property (p_wsync_start) else $error("word sync off slice"); // [RQ8]
  property p_one_lane;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      (lsel == lanes_zero && $stable(lsel)) |-> lane_r == 2'h0;
  endproperty
  a_one_lane: assert property (p_one_lane) else $error("lane moved in single mode"); // [RQ3]
  property p_two_lane;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      (lsel == lanes_zero_two && st_r == st_data) |-> lane_r != 2'h1 && lane_r != 2'h3;
  endproperty
  a_two_lane: assert property (p_two_lane) else $error("wrong lane pair"); // [RQ2]
  property p_begin;
    @(posedge ref_clk_i) disable iff (!rst_n_i || boot_r)
      $rose(stream_frame_count_cfg[`BIT_STREAM_BEGIN_CMD]) && !stream_frame_count_cfg[`BIT_STREAM_END_CMD] |=> active_r;
  endproperty
  a_begin: assert property (p_begin) else $error("begin edge ignored"); // [RQ21]
  property p_end;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      $rose(stream_frame_count_cfg[`BIT_STREAM_END_CMD]) |=> !active_r ##0 !stream_clk_en_o;
  endproperty
  a_end: assert property (p_end) else $error("end edge ignored"); // [RQ21]
  property p_strap_hold;
    @(posedge ref_clk_i) disable iff (!rst_n_i || boot_r)
      strap_mode_pin_i |=> regs_r[0] == $past(regs_r[0]);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("write in strap mode"); // [RQ12]
  property p_boot_default;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      (boot_r && !strap_mode_pin_i) |=> regs_r[0] == `RST_RECEIVER_IF_CONFIG
        && regs_r[2] == `RST_SUPPORT_STREAM_CONFIG;
  endproperty
  a_boot_default: assert property (p_boot_default) else $error("bad power-on value"); // [RQ14]
  property p_tsync_gap;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      time_sync_o |=> !time_sync_o;
  endproperty
  a_tsync_gap: assert property (p_tsync_gap) else $error("time sync too long"); // [RQ9]
  c_stream: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) st_r == st_data);
  c_stamp: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) st_r == st_stamp);
  c_tsync: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) time_sync_o);
endmodule : cfg_stream_top
`default_nettype wire

//--- test/stream_sink_model.sv
`timescale 1ns/1ps
`default_nettype none
module stream_sink_model (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // pacing of the stream clock
  input wire logic [1:0] gap_i,
  output logic stream_tick_o,
  // serial stream
  input wire logic stream_data_i,
  input wire logic word_sync_i,
  // captured slices
  output logic [15:0] slice_o,
  output logic slice_valid_o,
  output logic stray_o
);
  logic [1:0] pace_r;
  logic tick_d_r;
  logic [4:0] cnt_r;
  // ----------------------------------------
  // stream clock pacing and capture
  // ----------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      pace_r <= 2'h0;
      stream_tick_o <= 1'b0;
      tick_d_r <= 1'b0;
      cnt_r <= 5'h0;
      slice_o <= 16'h0;
      slice_valid_o <= 1'b0;
      stray_o <= 1'b0;
    end else begin
      // gap of 1 or 2 keeps the bit rate 8x or 4x the sample rate
      stream_tick_o <= (pace_r + 2'h1 >= gap_i);
      pace_r <= (pace_r + 2'h1 >= gap_i) ? 2'h0 : pace_r + 2'h1;
      // register output moves one cycle after the tick
      tick_d_r <= stream_tick_o;
      slice_valid_o <= 1'b0;
      if (tick_d_r) begin
        if (word_sync_i) begin
          slice_o <= {15'h0, stream_data_i};
          cnt_r <= 5'h1;
        end else if (cnt_r != 5'h0) begin
          slice_o <= {slice_o[14:0], stream_data_i};
          cnt_r <= (cnt_r == 5'hf) ? 5'h0 : cnt_r + 5'h1;
          slice_valid_o <= (cnt_r == 5'hf);
        end else if (stream_data_i) begin
          stray_o <= 1'b1;
        end
      end
    end
  end
endmodule : stream_sink_model
`default_nettype wire

//--- test/config_port_and_sample_streamer_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin miscompares++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); end end
module config_port_and_sample_streamer_test import cfg_stream_pkg::*;;
  logic clk, rst_n, strap, sclk, sdi, sel_n, adc_tick, sdo, clk_en, wsync, tsync, byp, src;
  logic stick, sl_valid, stray, ts_seen;
  logic [3:0] adc_bits;
  logic [1:0] gap;
  logic [15:0] seed, slice, exp_sl;
  logic [31:0] ts_cnt;
  cfg_word_t regs [10];
  cfg_word_t exp_regs [10];
  cfg_word_t dflt [10] = '{28'ha2919a3, 28'h055028c, 28'heafe1dc, 28'h9ec0008, 28'h0c00080,
    28'h8000070, 28'h8000000, 28'h10061b2, 28'h1e0f401, 28'h28c0402};
  cfg_word_t st0 [8] = '{28'ha2919a3, 28'ha2919a3, 28'ha2919a7, 28'ha2919a3, 28'ha2919a3,
    28'ha293573, 28'ha293573, 28'ha29b26b};
  cfg_word_t st1 [8] = '{28'h055121c, 28'h055028c, 28'h055121c, 28'h055028c, 28'h055028c,
    28'h855030c, 28'h855030c, 28'h855030c};
  cfg_word_t st4 [8] = '{28'h0c00080, 28'h0c00080, 28'h0c00080, 28'h0c00100, 28'h3d62300,
    28'h0ba00d0, 28'h0c00080, 28'h0bc80d0};
  logic [15:0] q [$];
  int miscompares = 0;
  int total_checks = 0;
  int cyc = 0;
  // ----------------------------------------
  // design and far-side model
  // ----------------------------------------
  cfg_stream_top #(.TSYNC_PERIOD(128)) u_dut (.ref_clk_i(clk), .rst_n_i(rst_n),
    .strap_mode_pin_i(strap), .cfg_sclk_i(sclk), .cfg_serial_in_i(sdi), .cfg_sel_n_i(sel_n),
    .adc_bits_i(adc_bits), .adc_tick_i(adc_tick), .stream_tick_i(stick), .stream_data_o(sdo),
    .stream_clk_en_o(clk_en), .word_sync_out_o(wsync), .time_sync_o(tsync),
    .frac_divider_bypass_o(byp), .sample_clock_source_o(src), .cfg_regs_o(regs));
  stream_sink_model u_sink (.ref_clk_i(clk), .rst_n_i(rst_n), .gap_i(gap),
    .stream_tick_o(stick), .stream_data_i(sdo), .word_sync_i(wsync), .slice_o(slice),
    .slice_valid_o(sl_valid), .stray_o(stray));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] lfsr(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic step(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic cfg_write(logic [31:0] w, int nbits);
    sel_n = 1'b0;
    step(1);
    // data msb first, address last
    for (int b = 31; b > 31 - nbits; b--) begin
      sdi = w[b];
      sclk = 1'b0;
      step(1);
      sclk = 1'b1;
      step(1);
    end
    sclk = 1'b0;
    step(1);
    sel_n = 1'b1;
    step(3);
  endtask : cfg_write
  task automatic wr(logic [3:0] a, cfg_word_t d);
    cfg_write({d, a}, 32);
    if (a <= 4'h9 && !strap) exp_regs[a] = d;
  endtask : wr
  task automatic cmp_regs();
    for (int i = 0; i < 10; i++) `CHK(regs[i], exp_regs[i])
  endtask : cmp_regs
  task automatic hard_reset(logic s, logic [2:0] pins);
    rst_n = 1'b0;
    strap = s;
    {sclk, sdi, sel_n} = pins;
    step(10);
    rst_n = 1'b1;
    step(2);
    exp_regs = dflt;
  endtask : hard_reset
  function automatic cfg_word_t stream_frame_count_word(logic bg, logic en, logic [1:0] ls);
    return {16'heafe, 1'b1, bg, en, 3'b111, ls, 4'b0110};
  endfunction : stream_frame_count_word
  task automatic feed_block(logic [1:0] ls);
    logic [15:0] sl [4];
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      adc_bits = seed[3:0];
      for (int l = 0; l < 4; l++) sl[l][15 - i] = seed[l];
      adc_tick = 1'b1;
      step(1);
      adc_tick = 1'b0;
      step(7);
    end
    q.push_back(sl[0]);
    if (ls != 2'h0) q.push_back(sl[(ls == 2'h2) ? 2 : 1]);
    if (ls == 2'h3) q.push_back(sl[2]);
    if (ls == 2'h3) q.push_back(sl[3]);
  endtask : feed_block
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict
  // ----------------------------------------
  // clock, monitors, timeout
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(negedge clk) begin
    if (sl_valid) begin
      exp_sl = (q.size() > 0) ? q.pop_front() : ~slice;
      `CHK(slice, exp_sl)
    end
    if (adc_tick) ts_cnt++;
    if (tsync) begin
      if (ts_seen) `CHK(ts_cnt, 32'd128)
      ts_seen = 1'b1;
      ts_cnt = 0;
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      give_verdict();
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {rst_n, strap, sclk, sdi, adc_tick, ts_seen} = '0;
    sel_n = 1'b1;
    adc_bits = 4'h0;
    gap = 2'h1;
    ts_cnt = 0;
    seed = 16'd11580;
    step(10);
    rst_n = 1'b1;
    step(2);
    exp_regs = dflt;
    cmp_regs();
    for (int s = 0; s < 8; s++) begin
      hard_reset(1'b1, s[2:0]);
      exp_regs[0] = st0[s];
      exp_regs[1] = st1[s];
      exp_regs[4] = st4[s];
      exp_regs[9] = (s == 7) ? 28'h7cc0403 : 28'h28c0402;
      cmp_regs();
    end
    wr(4'h0, 28'h1234567);
    cmp_regs();
    $display("test presets done");
    hard_reset(1'b0, 3'b001);
    cmp_regs();
    for (int a = 0; a < 10; a++) begin
      seed = lfsr(seed);
      wr(a[3:0], {seed[11:0], lfsr(seed)});
    end
    cmp_regs();
    wr(4'ha, 28'h5a5a5a5);
    wr(4'hf, 28'h0f0f0f0);
    cfg_write({28'h7777777, 4'h6}, 31);
    cmp_regs();
    for (int k = 0; k < 4; k++) begin
      wr(4'h7, {k[1:0], 26'h00061b2});
      `CHK(byp, k[1])
      `CHK(src, k[0])
    end
    $display("test register port done");
    for (int ls = 0; ls < 4; ls++) begin
      gap = (ls == 1 || ls == 2) ? 2'h2 : 2'h1;
      wr(4'h2, stream_frame_count_word(1'b0, 1'b0, ls[1:0]));
      wr(4'h2, stream_frame_count_word(1'b1, 1'b0, ls[1:0]));
      `CHK(clk_en, 1'b1)
      repeat (5) feed_block(ls[1:0]);
      step(150);
    end
    // counter reset zeroes the frame number, so the first stamp is all zeros
    gap = 2'h1;
    wr(4'h2, stream_frame_count_word(1'b1, 1'b0, 2'h0) | 28'h1);
    wr(4'h2, stream_frame_count_word(1'b1, 1'b0, 2'h0) | 28'h8);
    q.push_back(16'h0000);
    feed_block(2'h0);
    step(150);
    wr(4'h2, stream_frame_count_word(1'b0, 1'b1, 2'h3));
    `CHK(clk_en, 1'b0)
    `CHK(q.size(), 0)
    `CHK(stray, 1'b0)
    `CHK(ts_seen, 1'b1)
    $display("test stream done");
    give_verdict();
  end
endmodule : config_port_and_sample_streamer_test
`default_nettype wire
